// ### logic/ccl_pkg.sv
// shared constants and types of the comparator control logic
package ccl_pkg;

	// ====================================================
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ====================================================
	// register offsets
	localparam logic [7:0] CSR_OFFSET      = 8'h08;
	localparam logic [7:0] EVT_STAT_OFFSET = 8'h0C;
	localparam logic [7:0] EVT_MASK_OFFSET = 8'h0D;

	// ====================================================
	// field positions of the control and status register
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_RESERVED  = 6;
	localparam int BIT_OUT_LEVEL = 5;
	localparam int BIT_FLAG      = 4;
	localparam int BIT_IRQ_EN    = 3;
	localparam int BIT_ROUTE     = 2;
	localparam int BIT_MODE_HI   = 1;
	localparam int BIT_MODE_LO   = 0;

	// ====================================================
	// reset values
	localparam logic [7:0] CSR_RESET      = 8'h00;
	localparam logic [1:0] EVT_RESET      = 2'h0;
	localparam logic [7:0] RDATA_IDLE     = 8'h00;

	// ====================================================
	// event status layout (sticky bits, write one to clear)
	localparam int EVT_W          = 2;
	localparam int EVT_BIT_MATCH  = 0;
	localparam int EVT_BIT_TOGGLE = 1;

	// ====================================================
	// synchroniser depth for the comparator decision
	localparam int SYNC_STAGES = 3;

	// ====================================================
	// event mode select encodings
	typedef enum logic [1:0] {
		MODE_TOGGLE   = 2'h0,
		MODE_RESERVED = 2'h1,
		MODE_FALL     = 2'h2,
		MODE_RISE     = 2'h3
	} ccl_mode_type;

	// control and status register image, bit 7 down to bit 0
	typedef struct packed {
		logic         power_off;
		logic         reserved;
		logic         out_level;
		logic         flag;
		logic         irq_en;
		logic         route;
		ccl_mode_type mode;
	} ccl_csr_type;

	// one register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ccl_req_type;

endpackage

// ### logic/ccl_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module ccl_sync #(
	parameter int STAGES = 3
) (
	input  logic clk,
	input  logic rst_n,
	input  logic ce,
	input  logic d,
	output logic q
);

	logic [STAGES-1:0] chain;

	// ====================================================
	// shift chain; only the next stage reads the first flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain <= '0;
		end else if (ce) begin
			chain <= {chain[STAGES-2:0], d};
		end
	end

	// ====================================================
	// accept a change only once the last two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else if (ce && chain[STAGES-1] == chain[STAGES-2]) begin
			q <= chain[STAGES-1];
		end
	end

endmodule

// ### logic/ccl_edge.sv
// edge detector that picks the flagged event by mode
`timescale 1ns/10ps
module ccl_edge (
	input  logic                 clk,
	input  logic                 rst_n,
	input  logic                 ce,
	input  logic                 level,
	input  ccl_pkg::ccl_mode_type mode,
	output logic                 hit,
	output logic                 toggle
);

	logic prev;

	// ====================================================
	// previous level; frozen with the clock enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
		end else if (ce) begin
			prev <= level;
		end
	end

	// ====================================================
	// event select; the reserved code never fires
	always_comb begin
		toggle = ce && (prev != level);
		unique case (mode)
			ccl_pkg::MODE_TOGGLE:   hit = toggle;
			ccl_pkg::MODE_RESERVED: hit = 1'b0;
			ccl_pkg::MODE_FALL:     hit = toggle && !level;
			ccl_pkg::MODE_RISE:     hit = toggle && level;
		endcase
	end

endmodule

// ### logic/ccl_top.sv
// comparator control and status logic, top level
//
// What this block does
// RULE_01 - output level is high when positive input exceeds negative input
// RULE_02 - bit 7 is read/write and powers the comparator off when set
// RULE_03 - software clears irq enable before changing the power-off bit
// RULE_04 - bit 6 is reserved, reads zero, ignores writes
// RULE_05 - bit 5 is read-only and shows the present output level
// RULE_06 - bit 4 flag sets when a transition matches the selected mode
// RULE_07 - irq requested only with flag, enable bit 3 and global bit
// RULE_08 - flag clears on vector execution or written one; zero ignored
// RULE_09 - bit 2 routes the output to the timer capture front end
// RULE_10 - software must also enable the timer capture interrupt
// RULE_11 - bits 1:0 select toggle, reserved, falling or rising edge
// RULE_12 - software clears irq enable before changing mode bits
// RULE_13 - single-bit set or clear on other bits clears a set flag
// RULE_14 - comparator output is synchronised before edge detection
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module ccl_top (
	input  logic       MCLK,
	input  logic       RST_N,
	input  logic       CE,
	input  logic [7:0] ADDR,
	input  logic [7:0] WDATA,
	input  logic       WR,
	input  logic       RD,
	output logic [7:0] RDATA,
	input  logic       COMP_RAW,
	input  logic       GLOBAL_IRQ_EN,
	input  logic       VECTOR_ACK,
	output logic       COMP_POWER_OFF,
	output logic       COMP_IRQ,
	output logic       CAPTURE_INPUT,
	output logic       IRQ
);

	// ====================================================
	// declarations
	ccl_pkg::ccl_req_type  req;
	ccl_pkg::ccl_csr_type  csr_view;
	logic                  power_off;
	logic                  flag;
	logic                  irq_en;
	logic                  route;
	ccl_pkg::ccl_mode_type mode;
	logic                  out_level;
	logic                  gated_raw;
	logic                  hit;
	logic                  toggle;
	logic                  csr_wr;
	logic                  stat_wr;
	logic                  mask_wr;
	logic [ccl_pkg::EVT_W-1:0] evt_stat;
	logic [ccl_pkg::EVT_W-1:0] evt_mask;
	logic [ccl_pkg::EVT_W-1:0] evt_set;
	logic [ccl_pkg::EVT_W-1:0] next_evt_stat;
	logic                  next_flag;
	logic [7:0]            next_rdata;

	// ====================================================
	// request bundle and address decode
	assign req.addr  = ADDR;
	assign req.wdata = WDATA;
	assign req.wr    = WR;
	assign req.rd    = RD;
	assign csr_wr  = CE && req.wr && req.addr == ccl_pkg::CSR_OFFSET;
	assign stat_wr = CE && req.wr
		&& req.addr == ccl_pkg::EVT_STAT_OFFSET;
	assign mask_wr = CE && req.wr
		&& req.addr == ccl_pkg::EVT_MASK_OFFSET;

	// ====================================================
	// comparator decision path
	// a powered-off comparator reads low instead of floating
	assign gated_raw = COMP_RAW && !power_off; // RULE_01

	// the analog decision is asynchronous to MCLK
	ccl_sync #(
		.STAGES (ccl_pkg::SYNC_STAGES)
	) u_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.ce    (CE),
		.d     (gated_raw),
		.q     (out_level)
	); // RULE_14

	ccl_edge u_edge (
		.clk    (MCLK),
		.rst_n  (RST_N),
		.ce     (CE),
		.level  (out_level),
		.mode   (mode),
		.hit    (hit),
		.toggle (toggle)
	); // RULE_11

	// ====================================================
	// power-off control, writable at any moment
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			power_off <= ccl_pkg::CSR_RESET[ccl_pkg::BIT_POWER_OFF];
		end else if (csr_wr) begin
			power_off <= req.wdata[ccl_pkg::BIT_POWER_OFF]; // RULE_02
		end
	end

	// ====================================================
	// enable, route and mode fields
	// changing enable or mode while armed may raise a
	// spurious flag; software is expected to disarm first
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_en <= ccl_pkg::CSR_RESET[ccl_pkg::BIT_IRQ_EN];
			route  <= ccl_pkg::CSR_RESET[ccl_pkg::BIT_ROUTE];
			mode   <= ccl_pkg::ccl_mode_type'(
				ccl_pkg::CSR_RESET[ccl_pkg::BIT_MODE_HI:
					ccl_pkg::BIT_MODE_LO]);
		end else if (csr_wr) begin
			irq_en <= req.wdata[ccl_pkg::BIT_IRQ_EN];
			route  <= req.wdata[ccl_pkg::BIT_ROUTE]; // RULE_09
			mode   <= ccl_pkg::ccl_mode_type'(
				req.wdata[ccl_pkg::BIT_MODE_HI:
					ccl_pkg::BIT_MODE_LO]); // RULE_11
		end
	end

	// ====================================================
	// event flag: set wins over either clear
	// a read-modify-write that sees the flag set writes the
	// one back and so clears it; that is left to software
	always_comb begin
		next_flag = flag;
		if ((csr_wr && req.wdata[ccl_pkg::BIT_FLAG]) || VECTOR_ACK) begin
			next_flag = 1'b0; // RULE_08
		end
		if (hit) begin
			next_flag = 1'b1; // RULE_06
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			flag <= ccl_pkg::CSR_RESET[ccl_pkg::BIT_FLAG];
		end else if (CE) begin
			flag <= next_flag;
		end
	end

	// ====================================================
	// interrupt request toward the processor
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			COMP_IRQ <= 1'b0;
		end else if (CE) begin
			COMP_IRQ <= flag && irq_en && GLOBAL_IRQ_EN; // RULE_07
		end
	end

	// ====================================================
	// capture routing; no path while the route bit is clear
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			CAPTURE_INPUT <= 1'b0;
		end else if (CE) begin
			CAPTURE_INPUT <= route && out_level; // RULE_09
		end
	end

	// ====================================================
	// power-off pin straight from its field flop
	assign COMP_POWER_OFF = power_off; // RULE_02

	// ====================================================
	// sticky event status, write one to clear, set wins
	assign evt_set[ccl_pkg::EVT_BIT_MATCH]  = hit;
	assign evt_set[ccl_pkg::EVT_BIT_TOGGLE] = toggle;

	always_comb begin
		next_evt_stat = evt_stat;
		if (stat_wr) begin
			next_evt_stat = evt_stat & ~req.wdata[ccl_pkg::EVT_W-1:0];
		end
		next_evt_stat = next_evt_stat | evt_set;
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			evt_stat <= ccl_pkg::EVT_RESET;
		end else if (CE) begin
			evt_stat <= next_evt_stat;
		end
	end

	// ====================================================
	// event mask
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			evt_mask <= ccl_pkg::EVT_RESET;
		end else if (mask_wr) begin
			evt_mask <= req.wdata[ccl_pkg::EVT_W-1:0];
		end
	end

	// ====================================================
	// level interrupt, one cycle behind the status bits
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else if (CE) begin
			IRQ <= |(evt_stat & evt_mask);
		end
	end

	// ====================================================
	// read path; data stand until the next enabled cycle without a read, then idle
	always_comb begin
		csr_view.power_off = power_off;
		csr_view.reserved  = 1'b0; // RULE_04
		csr_view.out_level = out_level; // RULE_05
		csr_view.flag      = flag;
		csr_view.irq_en    = irq_en;
		csr_view.route     = route;
		csr_view.mode      = mode;
		next_rdata = ccl_pkg::RDATA_IDLE;
		if (req.rd) begin
			unique case (req.addr)
				ccl_pkg::CSR_OFFSET: next_rdata = csr_view;
				ccl_pkg::EVT_STAT_OFFSET:
					next_rdata = {{(8-ccl_pkg::EVT_W){1'b0}}, evt_stat};
				ccl_pkg::EVT_MASK_OFFSET:
					next_rdata = {{(8-ccl_pkg::EVT_W){1'b0}}, evt_mask};
				default: next_rdata = ccl_pkg::RDATA_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= ccl_pkg::RDATA_IDLE;
		end else if (CE) begin
			RDATA <= next_rdata;
		end
	end

	// ====================================================
	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// a decision held steady long enough reaches the level
	sequence raw_high_held;
		(CE && COMP_RAW && !power_off)[*5];
	endsequence

	sequence raw_low_held;
		(CE && !gated_raw)[*5];
	endsequence

	a_level_high: assert property ( // RULE_01
		raw_high_held |-> out_level)
		else $error("level not high after steady high input");

	a_level_low: assert property ( // RULE_14
		raw_low_held |-> !out_level)
		else $error("level not low after steady low input");

	a_power_write: assert property ( // RULE_02
		csr_wr |=> COMP_POWER_OFF == $past(WDATA[ccl_pkg::BIT_POWER_OFF]))
		else $error("power-off bit did not take written value");

	a_reserved_zero: assert property ( // RULE_04
		CE && RD && ADDR == ccl_pkg::CSR_OFFSET
		|=> RDATA[ccl_pkg::BIT_RESERVED] == 1'b0)
		else $error("reserved bit read non-zero");

	a_level_readback: assert property ( // RULE_05
		CE && RD && ADDR == ccl_pkg::CSR_OFFSET
		|=> RDATA[ccl_pkg::BIT_OUT_LEVEL] == $past(out_level))
		else $error("level readback differs from live level");

	a_flag_sets: assert property ( // RULE_06
		CE && hit |=> flag)
		else $error("flag missed a matching edge");

	a_rise_only: assert property ( // RULE_11
		CE && mode == ccl_pkg::MODE_RISE && $fell(out_level) |-> !hit)
		else $error("falling edge flagged in rising mode");

	a_mode_reserved: assert property ( // RULE_11
		mode == ccl_pkg::MODE_RESERVED |-> !hit)
		else $error("reserved mode raised an event");

	a_irq_gate: assert property ( // RULE_07
		CE |=> COMP_IRQ == $past(flag && irq_en && GLOBAL_IRQ_EN))
		else $error("irq request does not follow its gate");

	a_flag_w1c: assert property ( // RULE_08
		csr_wr && WDATA[ccl_pkg::BIT_FLAG] && !hit |=> !flag)
		else $error("written one did not clear the flag");

	a_flag_vector: assert property ( // RULE_08
		CE && VECTOR_ACK && !hit |=> !flag)
		else $error("vector execution did not clear the flag");

	a_flag_keep: assert property ( // RULE_08
		csr_wr && !WDATA[ccl_pkg::BIT_FLAG] && flag && !VECTOR_ACK
		|=> flag)
		else $error("written zero disturbed the flag");

	a_route_gate: assert property ( // RULE_09
		CE |=> CAPTURE_INPUT == $past(route && out_level))
		else $error("capture path does not follow the route bit");

	// an unpowered core may chatter; the gate keeps it off the flag
	sequence power_off_held;
		(CE && power_off)[*5];
	endsequence

	a_power_level: assert property ( // RULE_02
		power_off_held |-> !out_level)
		else $error("level not low while powered off");

	a_toggle_any: assert property ( // RULE_11
		CE && mode == ccl_pkg::MODE_TOGGLE && $changed(out_level)
		|-> hit)
		else $error("toggle mode missed an edge");

	a_rise_hit: assert property ( // RULE_06
		CE && mode == ccl_pkg::MODE_RISE && $rose(out_level)
		|-> hit)
		else $error("rising mode missed a rising edge");

	a_fall_hit: assert property ( // RULE_06
		CE && mode == ccl_pkg::MODE_FALL && $fell(out_level)
		|-> hit)
		else $error("falling mode missed a falling edge");

	a_fall_only: assert property ( // RULE_11
		CE && mode == ccl_pkg::MODE_FALL && $rose(out_level)
		|-> !hit)
		else $error("rising edge flagged in falling mode");

	a_irq_block: assert property ( // RULE_07
		CE && !irq_en |=> !COMP_IRQ)
		else $error("irq request with enable clear");

	a_global_block: assert property ( // RULE_07
		CE && !GLOBAL_IRQ_EN |=> !COMP_IRQ)
		else $error("irq request with global bit clear");

	a_route_off: assert property ( // RULE_09
		CE && !route |=> !CAPTURE_INPUT)
		else $error("capture path live with route bit clear");

endmodule

// ### tb/ccl_partner.sv
// behavioural comparator core and timer capture front end
`timescale 1ns/10ps
module ccl_partner (
	input  logic        clk,
	input  logic        rst_n,
	input  logic [15:0] pos_mv,
	input  logic [15:0] neg_mv,
	input  logic        power_off,
	input  logic        capture_in,
	input  logic        capture_irq_en,
	output logic        decision,
	output logic [7:0]  capture_count
);
	logic chatter;
	logic capture_q;

	// ====================
	// comparator core
	// unpowered core has no defined output, so it wanders every cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			chatter <= 1'b0;
		else
			chatter <= ~chatter;
	end
	// high while positive input lies above negative input
	assign decision = power_off ? chatter : (pos_mv > neg_mv);

	// ====================
	// timer capture front end
	// counts rising edges only while its interrupt enable is set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_q     <= 1'b0;
			capture_count <= 8'h00;
		end else begin
			capture_q <= capture_in;
			if (capture_in && !capture_q && capture_irq_en)
				capture_count <= capture_count + 8'h01;
		end
	end
endmodule

// ### tb/testbench.sv
// self-checking bench for the comparator control logic
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; \
	if ((got) !== (exp)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module testbench;
	localparam logic [7:0] CSR = ccl_pkg::CSR_OFFSET;
	localparam logic [7:0] STA = ccl_pkg::EVT_STAT_OFFSET;
	localparam logic [7:0] MSK = ccl_pkg::EVT_MASK_OFFSET;
	logic        mclk   = 1'b0;
	logic        rst_n  = 1'b0;
	logic        ce     = 1'b1;
	logic [7:0]  addr   = 8'h00;
	logic [7:0]  wdata  = 8'h00;
	logic        wr     = 1'b0;
	logic        rd     = 1'b0;
	logic        gie    = 1'b0;
	logic        vack   = 1'b0;
	logic [15:0] pos_mv = 16'h01f4;
	logic [15:0] neg_mv = 16'h03e8;
	logic        tmr_ie = 1'b1;
	logic [7:0]  rdata;
	logic        raw;
	logic        poff;
	logic        cirq;
	logic        cap;
	logic        irq;
	logic [7:0]  ncap;
	logic [7:0]  rv;
	logic        f;
	int          fails    = 0;
	int          n_checks = 0;

	// ====================
	// clock and instances
	always #12.5 mclk = ~mclk;
	ccl_top i_ccl_top (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .COMP_RAW(raw),
		.GLOBAL_IRQ_EN(gie), .VECTOR_ACK(vack), .COMP_POWER_OFF(poff),
		.COMP_IRQ(cirq), .CAPTURE_INPUT(cap), .IRQ(irq));
	ccl_partner i_ccl_partner (.clk(mclk), .rst_n(rst_n), .pos_mv(pos_mv),
		.neg_mv(neg_mv), .power_off(poff), .capture_in(cap),
		.capture_irq_en(tmr_ie), .decision(raw), .capture_count(ncap));

	// ====================
	// bus and helper tasks
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// move the analog input and let the synchroniser settle
	task automatic drive(input logic hi);
		@(posedge mclk);
		pos_mv <= hi ? 16'h05dc : 16'h01f4;
		cyc(7);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		test_done;
	end

	// ====================
	// main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd_reg(CSR);
		`CHK("csr reset", 8'h00, rv)
		rd_reg(STA);
		`CHK("status reset", 8'h00, rv)
		rd_reg(8'h3f);
		`CHK("unmapped", 8'h00, rv)
		cyc(1);
		`CHK("rdata idle", 8'h00, rdata)
		$display("test reset done");
		// clock enable low drops a write
		ce <= 1'b0;
		wr_reg(CSR, 8'h80);
		ce <= 1'b1;
		`CHK("ce gate", 1'b0, poff)
		wr_reg(CSR, 8'hf7);
		`CHK("power off", 1'b1, poff)
		drive(1);
		rd_reg(CSR);
		`CHK("csr fields", 8'h87, rv)
		drive(0);
		wr_reg(CSR, 8'h00);
		`CHK("power on", 1'b0, poff)
		$display("test fields done");
		// every mode against a rise then a fall
		for (int m = 0; m < 4; m++) begin
			wr_reg(CSR, 8'(m));
			drive(1);
			rd_reg(CSR);
			f = (m == 0 || m == 3);
			`CHK("rise", {3'b001, f, 2'b00, 2'(m)}, rv)
			wr_reg(CSR, 8'h10 | 8'(m));
			drive(0);
			rd_reg(CSR);
			f = (m == 0 || m == 2);
			`CHK("fall", {3'b000, f, 2'b00, 2'(m)}, rv)
			wr_reg(CSR, 8'h10 | 8'(m));
		end
		$display("test modes done");
		wr_reg(CSR, 8'h0b);
		gie <= 1'b1;
		drive(1);
		`CHK("irq on", 1'b1, cirq)
		wr_reg(CSR, 8'h0b);
		rd_reg(CSR);
		`CHK("zero kept", 8'h3b, rv)
		gie <= 1'b0;
		cyc(2);
		`CHK("global off", 1'b0, cirq)
		gie <= 1'b1;
		wr_reg(CSR, 8'h03);
		cyc(1);
		`CHK("enable off", 1'b0, cirq)
		wr_reg(CSR, 8'h0b);
		vack <= 1'b1;
		@(posedge mclk);
		vack <= 1'b0;
		cyc(2);
		`CHK("vector clr", 1'b0, cirq)
		rd_reg(CSR);
		`CHK("flag clr", 8'h2b, rv)
		gie <= 1'b0;
		drive(0);
		$display("test interrupt done");
		// event status and mask
		wr_reg(STA, 8'h03);
		wr_reg(CSR, 8'h03);
		drive(1);
		rd_reg(STA);
		`CHK("status", 8'h03, rv)
		`CHK("masked", 1'b0, irq)
		wr_reg(MSK, 8'h02);
		cyc(2);
		`CHK("unmasked", 1'b1, irq)
		rd_reg(MSK);
		`CHK("mask rd", 8'h02, rv)
		wr_reg(STA, 8'h02);
		cyc(2);
		`CHK("status clr", 1'b0, irq)
		rd_reg(STA);
		`CHK("status one", 8'h01, rv)
		drive(0);
		`CHK("toggle irq", 1'b1, irq)
		wr_reg(STA, 8'h03);
		wr_reg(MSK, 8'h00);
		wr_reg(CSR, 8'h13);
		$display("test events done");
		// capture route and synchroniser delay
		wr_reg(CSR, 8'h04);
		@(posedge mclk);
		pos_mv <= 16'h05dc;
		cyc(3);
		`CHK("sync hold", 1'b0, cap)
		cyc(3);
		`CHK("routed", 1'b1, cap)
		`CHK("captures", 8'h01, ncap)
		wr_reg(CSR, 8'h00);
		cyc(2);
		`CHK("unrouted", 1'b0, cap)
		$display("test route done");
		test_done;
	end
endmodule
